// ==== rtl/mfp_pkg.sv ====
// Constants for the multi-function output pin selector.
// Assumes a single 100 MHz system clock and byte-wide register accesses.
package mfp_pkg;

  localparam logic [7:0] CTRL_ADDR      = 8'h07;
  localparam logic [7:0] ALM0_WKDAY_ADDR = 8'h0D;
  localparam logic [7:0] ALM1_WKDAY_ADDR = 8'h14;

  localparam logic [7:0] CTRL_RESET     = 8'h80;
  localparam logic [7:0] WKDAY_RESET    = 8'h00;

  // Control register field positions
  localparam int OUT_LEVEL_BIT   = 7;
  localparam int SQW_ENABLE_BIT  = 6;
  localparam int ALM1_ENABLE_BIT = 5;
  localparam int ALM0_ENABLE_BIT = 4;
  localparam int EXT_CLK_BIT     = 3;
  localparam int COARSE_TRIM_BIT = 2;
  localparam int RATE_MSB        = 1;
  localparam int RATE_LSB        = 0;

  // Weekday/mask register field positions
  localparam int ALM_POL_BIT     = 7;
  localparam int ALM_FLAG_BIT    = 3;

  // Square-wave rate select codes
  localparam logic [1:0] RATE_DIV1     = 2'h0;
  localparam logic [1:0] RATE_DIV4     = 2'h1;
  localparam logic [1:0] RATE_DIV8     = 2'h2;
  localparam logic [1:0] RATE_DIV32768 = 2'h3;

  // Postscaler counter width and tap bits (tap n divides by 2^(n+1))
  localparam int PS_WIDTH     = 15;
  localparam int TAP_DIV4     = 1;
  localparam int TAP_DIV8     = 2;
  localparam int TAP_DIV512   = 8;
  localparam int TAP_DIV32768 = 14;

  localparam logic [PS_WIDTH-1:0] PS_RESET = 15'h0000;

endpackage : mfp_pkg

// ==== rtl/mfp_select.sv ====
// Multi-function open-drain pin selector with its control and alarm flag registers.
// Assumes a byte register port from the serial front end and alarm comparators
// on the system clock; oscillator and backup indication arrive asynchronously.
// Function
// - Control bits choose clock, alarm or level
// - Backup supply allows only alarm output
// - Pin is open drain: low or released
// - Rate select divides oscillator by 1/4/8/32768
// - Divided rates trimmed, undivided rate bypasses
// - Alarm mode follows enabled alarm flags
// - One alarm: flag or inverse by polarity
// - Two alarms: OR, or inverted AND
// - Flag set on match, sticky, software-clear
// - Weekday register write clears its flag
`timescale 1ns/1ps
module mfp_select
  import mfp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       osc_xtal_in,
  input  wire logic       osc_ext_in,
  input  wire logic       backup_supply_in,
  input  wire logic       trim_drop_in,
  input  wire logic       trim_insert_in,
  input  wire logic       alarm0_match_in,
  input  wire logic       alarm1_match_in,
  input  wire logic       multi_function_pin_in,
  output logic            multi_function_pin_out,
  output logic            multi_function_pin_oe_n_out
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] wkday0;
    logic [7:0] wkday1;
    logic       alarm0_match_flag;
    logic       alarm1_match_flag;
    logic [1:0] osc_sync;
    logic       osc_prev;
    logic [1:0] bkp_sync;
    logic [1:0] pin_sync;
    logic [7:0] rdata;
    logic       pin_low;
  } sel_state_t;

  sel_state_t st_ff;
  sel_state_t nxt_st;
  sqw_if      sq ();

  logic       osc_raw;
  logic       en0;
  logic       en1;
  logic       sqw_en;
  logic       polarity;
  logic       combined;
  logic       alarm_level;
  logic       pin_level;
  logic       wr_ctrl;
  logic       wr_wk0;
  logic       wr_wk1;

  // Source select happens before the synchroniser so only one path crosses
  assign osc_raw  = st_ff.ctrl[EXT_CLK_BIT] ? osc_ext_in : osc_xtal_in;
  assign en0      = st_ff.ctrl[ALM0_ENABLE_BIT];
  assign en1      = st_ff.ctrl[ALM1_ENABLE_BIT];
  assign sqw_en   = st_ff.ctrl[SQW_ENABLE_BIT];
  // Polarity is shared; alarm 0 copy is the one in force
  assign polarity = st_ff.wkday0[ALM_POL_BIT];
  assign wr_ctrl  = reg_wr_in && reg_addr_in == CTRL_ADDR;
  assign wr_wk0   = reg_wr_in && reg_addr_in == ALM0_WKDAY_ADDR;
  assign wr_wk1   = reg_wr_in && reg_addr_in == ALM1_WKDAY_ADDR;

  assign sq.osc_tick    = st_ff.osc_sync[1] & ~st_ff.osc_prev;
  assign sq.osc_level   = st_ff.osc_sync[1];
  assign sq.trim_drop   = trim_drop_in;
  assign sq.trim_insert = trim_insert_in;
  assign sq.rate_sel    = st_ff.ctrl[RATE_MSB:RATE_LSB];
  assign sq.coarse_trim = st_ff.ctrl[COARSE_TRIM_BIT];

  sqw_postscaler u_postscaler (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .sq        (sq.scaler)
  );

  always_comb begin
    if (en0 && en1) begin
      combined = polarity ? (st_ff.alarm0_match_flag | st_ff.alarm1_match_flag)
                          : (st_ff.alarm0_match_flag & st_ff.alarm1_match_flag);
    end else begin
      combined = en0 ? st_ff.alarm0_match_flag : st_ff.alarm1_match_flag;
    end
    alarm_level = polarity ? combined : ~combined;
  end

  always_comb begin
    if (st_ff.bkp_sync[1] && (sqw_en || !(en0 || en1))) begin
      pin_level = 1'b1;
    end else if (sqw_en) begin
      pin_level = sq.wave;
    end else if (en0 || en1) begin
      pin_level = alarm_level;
    end else begin
      pin_level = st_ff.ctrl[OUT_LEVEL_BIT];
    end
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.osc_sync = {st_ff.osc_sync[0], osc_raw};
    nxt_st.osc_prev = st_ff.osc_sync[1];
    nxt_st.bkp_sync = {st_ff.bkp_sync[0], backup_supply_in};
    nxt_st.pin_sync = {st_ff.pin_sync[0], multi_function_pin_in};
    nxt_st.pin_low  = ~pin_level;
    if (wr_ctrl) begin
      nxt_st.ctrl = reg_wdata_in;
    end
    // Flag bit is not storage here; software can only clear it
    if (wr_wk0) begin
      nxt_st.wkday0              = reg_wdata_in & 8'hF7;
      nxt_st.alarm0_match_flag   = 1'b0;
    end
    if (wr_wk1) begin
      nxt_st.wkday1              = reg_wdata_in & 8'hF7;
      nxt_st.alarm1_match_flag   = 1'b0;
    end
    // A match in the clearing cycle still wins
    if (alarm0_match_in) begin
      nxt_st.alarm0_match_flag = 1'b1;
    end
    if (alarm1_match_in) begin
      nxt_st.alarm1_match_flag = 1'b1;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        CTRL_ADDR:       nxt_st.rdata = st_ff.ctrl;
        ALM0_WKDAY_ADDR: nxt_st.rdata = st_ff.wkday0 | {4'h0, st_ff.alarm0_match_flag, 3'h0};
        ALM1_WKDAY_ADDR: nxt_st.rdata = st_ff.wkday1 | {4'h0, st_ff.alarm1_match_flag, 3'h0};
        default:         nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '{ctrl: CTRL_RESET, wkday0: WKDAY_RESET, wkday1: WKDAY_RESET,
                 alarm0_match_flag: 1'b0, alarm1_match_flag: 1'b0, osc_sync: 2'h0,
                 osc_prev: 1'b0, bkp_sync: 2'h0, pin_sync: 2'h3, rdata: 8'h00,
                 pin_low: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out               = st_ff.rdata;
  assign multi_function_pin_out      = 1'b0;
  assign multi_function_pin_oe_n_out = ~st_ff.pin_low;

  chk_gp_level: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!sqw_en && !en0 && !en1 && !st_ff.bkp_sync[1])
      |=> multi_function_pin_oe_n_out == $past(st_ff.ctrl[7]))
    else $error("general-purpose level not on pin");

  chk_backup_release: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_ff.bkp_sync[1] && (sqw_en || !(en0 || en1))) |=> multi_function_pin_oe_n_out)
    else $error("pin driven in backup outside alarm mode");

  chk_sqw_priority: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (sqw_en && !st_ff.bkp_sync[1]) |=> multi_function_pin_oe_n_out == $past(sq.wave))
    else $error("square wave not on pin while enabled");

  chk_single_alarm: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!sqw_en && en0 && !en1) |=>
      multi_function_pin_oe_n_out == ($past(polarity) ~^ $past(st_ff.alarm0_match_flag)))
    else $error("single alarm output wrong");

  chk_single_alarm1: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!sqw_en && !en0 && en1) |=>
      multi_function_pin_oe_n_out == ($past(polarity) ~^ $past(st_ff.alarm1_match_flag)))
    else $error("single alarm 1 output wrong");

  chk_dual_and: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!sqw_en && en0 && en1 && !polarity) |=>
      multi_function_pin_oe_n_out
        == !($past(st_ff.alarm0_match_flag) && $past(st_ff.alarm1_match_flag)))
    else $error("dual alarm inverted AND wrong");

  chk_dual_or: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!sqw_en && en0 && en1 && polarity) |=>
      multi_function_pin_oe_n_out
        == ($past(st_ff.alarm0_match_flag) || $past(st_ff.alarm1_match_flag)))
    else $error("dual alarm OR wrong");

  chk_flag_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_ff.alarm0_match_flag && !wr_wk0) |=> st_ff.alarm0_match_flag)
    else $error("alarm 0 flag dropped without a clearing write");

  chk_flag1_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_ff.alarm1_match_flag && !wr_wk1) |=> st_ff.alarm1_match_flag)
    else $error("alarm 1 flag dropped without a clearing write");

  chk_match_wins: assert property (@(posedge clk_in) disable iff (!resetn_in)
    alarm1_match_in |=> st_ff.alarm1_match_flag ##1 (st_ff.alarm1_match_flag || $past(wr_wk1)))
    else $error("alarm 1 match lost");

  chk_wkday_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_wk0 && !alarm0_match_in) |=> !st_ff.alarm0_match_flag)
    else $error("weekday write did not clear alarm 0 flag");

  chk_wkday1_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_wk1 && !alarm1_match_in) |=> !st_ff.alarm1_match_flag)
    else $error("weekday write did not clear alarm 1 flag");

  chk_open_drain: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !multi_function_pin_out)
    else $error("pin data not held low");

endmodule : mfp_select

// ==== rtl/sqw_if.sv ====
// Carrier between the pin selector and its square-wave postscaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface sqw_if;
  logic       osc_tick;
  logic       osc_level;
  logic       trim_drop;
  logic       trim_insert;
  logic [1:0] rate_sel;
  logic       coarse_trim;
  logic       wave;

  modport ctrl (output osc_tick, output osc_level, output trim_drop, output trim_insert,
                output rate_sel, output coarse_trim, input wave);
  modport scaler (input osc_tick, input osc_level, input trim_drop, input trim_insert,
                  input rate_sel, input coarse_trim, output wave);
endinterface : sqw_if

// ==== rtl/sqw_postscaler.sv ====
// Square-wave postscaler fed by oscillator ticks and trim pulses.
// Assumes ticks are one-cycle enables already in the system clock domain.
`timescale 1ns/1ps
module sqw_postscaler
  import mfp_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  sqw_if.scaler     sq
);

  typedef struct packed {
    logic [PS_WIDTH-1:0] cnt;
    logic                wave;
  } ps_state_t;

  ps_state_t st_ff;
  ps_state_t nxt_st;
  logic      trim_tick;

  // Trimming removes or adds oscillator cycles before the divider
  assign trim_tick = (sq.osc_tick & ~sq.trim_drop) | sq.trim_insert;

  always_comb begin
    nxt_st = st_ff;
    if (trim_tick) begin
      nxt_st.cnt = st_ff.cnt + 15'h0001;
    end
    if (sq.coarse_trim) begin
      nxt_st.wave = st_ff.cnt[TAP_DIV512];
    end else begin
      unique case (sq.rate_sel)
        RATE_DIV1:     nxt_st.wave = sq.osc_level;
        RATE_DIV4:     nxt_st.wave = st_ff.cnt[TAP_DIV4];
        RATE_DIV8:     nxt_st.wave = st_ff.cnt[TAP_DIV8];
        RATE_DIV32768: nxt_st.wave = st_ff.cnt[TAP_DIV32768];
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '{cnt: PS_RESET, wave: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sq.wave = st_ff.wave;

  chk_div4_tap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!sq.coarse_trim && sq.rate_sel == RATE_DIV4) |=> sq.wave == $past(st_ff.cnt[1]))
    else $error("wave does not follow divide-by-4 tap");

  chk_coarse_tap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sq.coarse_trim |=> sq.wave == $past(st_ff.cnt[8]))
    else $error("coarse trim does not select the 64 Hz tap");

  chk_drop_holds: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (sq.trim_drop && !sq.trim_insert) |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("dropped trim cycle still advanced the postscaler");

endmodule : sqw_postscaler

// ==== tb/mfp_line_model.sv ====
// Pulled-up line on the multi-function pin, read by the host side.
// Assumes the pin drives only low and releases otherwise.
`timescale 1ns/1ps
module mfp_line_model (
  input  wire logic pin_out_in,
  input  wire logic oe_n_in,
  output logic      line_out
);
  // Released pin reads high through the pull-up
  assign line_out = oe_n_in ? 1'b1 : pin_out_in;
endmodule : mfp_line_model

// ==== tb/tb.sv ====
// Self-checking bench for the multi-function pin selector.
// Assumes the line model as the pulled-up far side and a strobe register port.
`timescale 1ns/1ps
module tb;
  import mfp_pkg::*;
  logic       clk_in    = 1'b0;
  logic       resetn_in = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic       osc       = 1'b0;
  logic       osc_ext   = 1'b0;
  logic       ins       = 1'b0;
  logic       backup    = 1'b0;
  logic       drop      = 1'b0;
  logic [1:0] match     = 2'h0;
  logic [7:0] rdata;
  logic       pin_out;
  logic       oe_n;
  logic       line;
  logic [7:0] v;
  int         mismatches = 0;
  int         checked    = 0;
  int         n;
  logic [7:0] sqw_exp [4] = '{8'h50, 8'h14, 8'h0A, 8'h00};

  always #5 clk_in = ~clk_in;
  // Fast oscillator, 16 cycles a period, keeps divided rates short
  always begin
    repeat (8) @(posedge clk_in);
    #1 osc = ~osc;
  end
  // External source twice as fast, so a wrong source select shows in the count
  always begin
    repeat (4) @(posedge clk_in);
    #1 osc_ext = ~osc_ext;
  end

  mfp_select u_mfp_select (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .osc_xtal_in(osc),
    .osc_ext_in(osc_ext), .backup_supply_in(backup), .trim_drop_in(drop),
    .trim_insert_in(ins), .alarm0_match_in(match[0]), .alarm1_match_in(match[1]),
    .multi_function_pin_in(line), .multi_function_pin_out(pin_out),
    .multi_function_pin_oe_n_out(oe_n)
  );
  mfp_line_model u_mfp_line_model (.pin_out_in(pin_out), .oe_n_in(oe_n), .line_out(line));

  task automatic settle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    settle(1);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    settle(1);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    settle(1);
    addr = a;
    rd   = 1'b1;
    settle(1);
    rd = 1'b0;
    settle(1);
    d = rdata;
  endtask : rd_reg
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask : chk
  // Window of whole periods holds an exact count of rising edges
  task automatic rises(input int w, output int r);
    logic p;
    r = 0;
    p = line;
    repeat (w) begin
      settle(1);
      if (line === 1'b1 && p === 1'b0) r++;
      p = line;
    end
  endtask : rises
  function automatic logic exp_alarm(input int m, input int p, input logic [1:0] f);
    logic a;
    a = (m == 3) ? (p ? (f[0] | f[1]) : (f[0] & f[1])) : f[m-1];
    return p ? a : ~a;
  endfunction : exp_alarm
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    settle(4);
    resetn_in = 1'b1;
    rd_reg(CTRL_ADDR, v);
    chk("ctrl_reset", v, CTRL_RESET);
    chk("pin_reset", {7'h0, line}, 8'h01);
    wr_reg(CTRL_ADDR, 8'h00);
    settle(3);
    chk("pin_level", {7'h0, line}, 8'h00);
    wr_reg(8'h3F, 8'hFF);
    rd_reg(8'h3F, v);
    chk("unmapped", v, 8'h00);
    for (int m = 1; m < 4; m++) for (int p = 0; p < 2; p++) for (int k = 0; k < 4; k++) begin
      // Level bit opposite to the expected pin, so any leak into alarm mode shows
      wr_reg(CTRL_ADDR, {~exp_alarm(m, p, k[1:0]), 1'b0, m[1:0], 4'h0});
      wr_reg(ALM0_WKDAY_ADDR, {p[0], 7'h00});
      wr_reg(ALM1_WKDAY_ADDR, 8'h00);
      match = k[1:0];
      settle(1);
      match = 2'h0;
      settle(3);
      chk("alarm_pin", {7'h0, line}, {7'h0, exp_alarm(m, p, k[1:0])});
    end
    rd_reg(ALM0_WKDAY_ADDR, v);
    chk("flag_sticky", v, 8'h88);
    wr_reg(ALM0_WKDAY_ADDR, 8'h08);
    rd_reg(ALM0_WKDAY_ADDR, v);
    chk("flag_clear", v, 8'h00);
    match = 2'h1;
    wr_reg(ALM0_WKDAY_ADDR, 8'h00);
    rd_reg(ALM0_WKDAY_ADDR, v);
    chk("flag_reset", v, 8'h08);
    match = 2'h0;
    backup = 1'b1;
    settle(5);
    chk("backup_alarm", {7'h0, line}, 8'h00);
    wr_reg(CTRL_ADDR, 8'h00);
    settle(3);
    chk("backup_gp", {7'h0, line}, 8'h01);
    wr_reg(CTRL_ADDR, 8'h40);
    rises(640, n);
    chk("backup_sqw", n[7:0], 8'h00);
    chk("backup_line", {7'h0, line}, 8'h01);
    backup = 1'b0;
    for (int r = 0; r < 4; r++) begin
      wr_reg(CTRL_ADDR, {6'h10, r[1:0]});
      settle(300);
      rises(1280, n);
      chk("sqw_rate", n[7:0], sqw_exp[r]);
    end
    wr_reg(CTRL_ADDR, 8'h48);
    settle(100);
    rises(1280, n);
    chk("ext_clock", n[7:0], 8'hA0);
    // All trimmed ticks dropped: divided rates freeze, 1:1 still runs
    drop = 1'b1;
    wr_reg(CTRL_ADDR, 8'h41);
    settle(100);
    rises(1280, n);
    chk("trim_div4", n[7:0], 8'h00);
    wr_reg(CTRL_ADDR, 8'h40);
    settle(100);
    rises(1280, n);
    chk("trim_bypass", n[7:0], 8'h50);
    // An inserted tick every cycle makes the divide-by-8 tap run at clock/8
    ins = 1'b1;
    wr_reg(CTRL_ADDR, 8'h42);
    settle(100);
    rises(1280, n);
    chk("trim_insert", n[7:0], 8'hA0);
    ins  = 1'b0;
    drop = 1'b0;
    wr_reg(CTRL_ADDR, 8'h47);
    settle(8300);
    rises(16384, n);
    chk("coarse_64hz", n[7:0], 8'h02);
    // Mid-run reset must release the pin at once and restore control
    resetn_in = 1'b0;
    settle(2);
    chk("reset_line", {7'h0, line}, 8'h01);
    resetn_in = 1'b1;
    rd_reg(CTRL_ADDR, v);
    chk("reset_ctrl", v, CTRL_RESET);
    settle(3);
    chk("reset_pin", {7'h0, line}, 8'h01);
    stop_test();
  end
endmodule : tb
